// ### rtl/rslp_ctrl.sv
//
// Contract
// - Keep the cause of the latest reset readable in reset_cause_reg.
// - Power resets: power-on, brown-outs; user resets: pin, watchdog, soft.
// - Real-time counter, 32k sources, locked units: power resets only.
// - Debug reset by power and pin resets; the rest by every source.
// - Low reset pin generates external reset; pin has a pull-up.
// - Detector requests from system controller; watchdog from watchdog.
// - Processor reset request bit gives a software reset.
// - Wait-for-interrupt starts sleep; level from idle field, deep-sleep.
// - Idle 0 stops cpu; 1 also high-speed bus; 2 also peripheral bus.
// - Wake sources: idle0 sync/async, idle1 pbus/async, idle2/standby async.
// - Stopped domain halts modules even when their mask bit is set.
// - Sleep-on-exit also enters sleep on return from lowest ISR.
// - Unmasked sufficient-priority interrupt ends idle; clocks restart.
// - Deep-sleep plus wait-for-interrupt enters standby; regulator, RAM low.
// - Standby: on-demand off needs run-in-standby; on needs request too.
// - Idle: on-demand off runs; on-demand on runs when requested.
// - Any enabled asynchronous interrupt wakes from standby.
// - Clock-ready sets flag; enable-set one enables, enable-clear disables.
// - Interrupt request while flag and enable both set.
// - Writing one to a flag bit clears it; zero leaves it.
// - Manager runs in idle; frozen in standby until async interrupt.
// - Clock-ready reads zero after prescaler write until it takes effect.
// - Idle field two bits: 0,1,2 select levels, 3 reserved.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rslp_ctrl
	import rslp_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       por_req_in,
	input  wire logic       core_brownout_in,
	input  wire logic       io_brownout_in,
	input  wire logic       reset_pin_n_in,
	input  wire logic       wdog_reset_in,
	input  wire logic       cpu_soft_reset_request_in,
	input  wire logic       wait_for_interrupt_instr_in,
	input  wire logic       isr_exit_lowest_in,
	input  wire logic       sleep_on_isr_exit_in,
	input  wire logic       deep_sleep_select_in,
	input  wire logic       irq_sync_hs_in,
	input  wire logic       irq_sync_pbus_in,
	input  wire logic       irq_async_in,
	input  wire logic [7:0] osc_request_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	output logic            power_rst_n_out,
	output logic            debug_rst_n_out,
	output logic            sys_rst_n_out,
	output logic            cpu_clk_en_out,
	output logic            hs_clk_en_out,
	output logic            pbus_clk_en_out,
	output logic            main_clk_en_out,
	output logic      [7:0] hs_mod_clk_en_out,
	output logic      [7:0] pa_mod_clk_en_out,
	output logic      [7:0] osc_run_out,
	output logic            lowpower_out,
	output logic            irq_out
);
	import rslp_pkg::*;

	// ----------------------------------------------------------------
	// Reset source synchronisers
	// ----------------------------------------------------------------
	// Detectors and the pin are asynchronous; second and third agree.
	logic [5:0] s1_q, s2_q, s3_q;
	logic [5:0] src_q;
	wire  [5:0] src_raw = {cpu_soft_reset_request_in, wdog_reset_in,
		~reset_pin_n_in, io_brownout_in, core_brownout_in,
		por_req_in};
	wire  [5:0] src_agree = ~(s2_q ^ s3_q);
	wire  [5:0] src_d = (src_agree & s2_q) | (~src_agree & src_q);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_q  <= 6'h00;
			s2_q  <= 6'h00;
			s3_q  <= 6'h00;
			src_q <= 6'h00;
		end else begin
			s1_q  <= src_raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			src_q <= src_d;
		end
	end

	// ----------------------------------------------------------------
	// Reset classification and fan-out
	// ----------------------------------------------------------------
	wire power_rst = |src_q[2:0];
	wire pin_rst   = src_q[3];
	wire user_rst  = |src_q[5:3];
	wire any_rst   = power_rst | user_rst;
	// Reset outputs are registered, one cycle behind the filtered request
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			power_rst_n_out <= 1'b0;
			debug_rst_n_out <= 1'b0;
			sys_rst_n_out   <= 1'b0;
		end else begin
			power_rst_n_out <= ~power_rst;
			debug_rst_n_out <= ~(power_rst | pin_rst);
			sys_rst_n_out   <= ~any_rst;
		end
	end

	// Cause: priority power first, then pin, watchdog, software
	logic [7:0] cause_oh;
	always_comb begin
		cause_oh = 8'h00;
		if (src_q[0])      cause_oh[RSLP_CAUSE_POR]  = 1'b1;
		else if (src_q[1]) cause_oh[RSLP_CAUSE_CBOD] = 1'b1;
		else if (src_q[2]) cause_oh[RSLP_CAUSE_IBOD] = 1'b1;
		else if (src_q[3]) cause_oh[RSLP_CAUSE_EXT]  = 1'b1;
		else if (src_q[4]) cause_oh[RSLP_CAUSE_WDOG] = 1'b1;
		else if (src_q[5]) cause_oh[RSLP_CAUSE_SOFT] = 1'b1;
	end
	logic [7:0] reset_cause_reg_q;
	wire  [7:0] reset_cause_reg_d = any_rst ? cause_oh : reset_cause_reg_q;
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) reset_cause_reg_q <= RSLP_RESET_CAUSE_REG_RST;
		else          reset_cause_reg_q <= reset_cause_reg_d;
	end

	// ----------------------------------------------------------------
	// Register file (cleared by system reset, cause kept)
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	logic [1:0] idle_q;
	logic [2:0] cpudiv_q, padiv_q, pbdiv_q, pcdiv_q;
	logic [7:0] hsmask_q, pamask_q, pbmask_q, pcmask_q, osccfg_q;
	logic       ien_q, iflag_q, clock_ready_flag_q;
	logic [3:0] ckcnt_q;
	wire wr = reg_wr_in;
	wire w_sleep  = wr & hit(reg_addr_in, RSLP_OFF_SLEEP);
	wire w_cpu    = wr & hit(reg_addr_in, RSLP_OFF_CPUSEL);
	wire w_pa     = wr & hit(reg_addr_in, RSLP_OFF_APBASEL);
	wire w_pb     = wr & hit(reg_addr_in, RSLP_OFF_APBBSEL);
	wire w_pc     = wr & hit(reg_addr_in, RSLP_OFF_APBCSEL);
	wire w_hsm    = wr & hit(reg_addr_in, RSLP_OFF_HSMASK);
	wire w_pam    = wr & hit(reg_addr_in, RSLP_OFF_PAMASK);
	wire w_pbm    = wr & hit(reg_addr_in, RSLP_OFF_PBMASK);
	wire w_pcm    = wr & hit(reg_addr_in, RSLP_OFF_PCMASK);
	wire w_iclr   = wr & hit(reg_addr_in, RSLP_OFF_IENCLR);
	wire w_iset   = wr & hit(reg_addr_in, RSLP_OFF_IENSET);
	wire w_iflag  = wr & hit(reg_addr_in, RSLP_OFF_IFLAG);
	wire w_osc    = wr & hit(reg_addr_in, RSLP_OFF_OSCCFG);
	wire w_presc  = w_cpu | w_pa | w_pb | w_pc;
	wire ck_b     = reg_wdata_in[RSLP_CLOCK_READY_FLAG_BIT];

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			idle_q   <= RSLP_IDLE_RST;
			cpudiv_q <= RSLP_DIV_RST;
			padiv_q  <= RSLP_DIV_RST;
			pbdiv_q  <= RSLP_DIV_RST;
			pcdiv_q  <= RSLP_DIV_RST;
			hsmask_q <= RSLP_HSMASK_RST;
			pamask_q <= RSLP_PAMASK_RST;
			pbmask_q <= RSLP_PBMASK_RST;
			pcmask_q <= RSLP_PCMASK_RST;
			osccfg_q <= RSLP_OSC_RST;
		end else if (any_rst) begin
			idle_q   <= RSLP_IDLE_RST;
			cpudiv_q <= RSLP_DIV_RST;
			padiv_q  <= RSLP_DIV_RST;
			pbdiv_q  <= RSLP_DIV_RST;
			pcdiv_q  <= RSLP_DIV_RST;
			hsmask_q <= RSLP_HSMASK_RST;
			pamask_q <= RSLP_PAMASK_RST;
			pbmask_q <= RSLP_PBMASK_RST;
			pcmask_q <= RSLP_PCMASK_RST;
			osccfg_q <= RSLP_OSC_RST;
		end else begin
			if (w_sleep) idle_q   <= reg_wdata_in[1:0];
			if (w_cpu)   cpudiv_q <= reg_wdata_in[2:0];
			if (w_pa)    padiv_q  <= reg_wdata_in[2:0];
			if (w_pb)    pbdiv_q  <= reg_wdata_in[2:0];
			if (w_pc)    pcdiv_q  <= reg_wdata_in[2:0];
			if (w_hsm)   hsmask_q <= reg_wdata_in;
			if (w_pam)   pamask_q <= reg_wdata_in;
			if (w_pbm)   pbmask_q <= reg_wdata_in;
			if (w_pcm)   pcmask_q <= reg_wdata_in;
			if (w_osc)   osccfg_q <= reg_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Clock-ready flag and interrupt
	// ----------------------------------------------------------------
	wire ck_event = (ckcnt_q == 4'h1); // Setting takes effect
	wire ien_d   = w_iset & ck_b ? 1'b1 :
		(w_iclr & ck_b ? 1'b0 : ien_q);
	// Set wins over a simultaneous clear
	wire iflag_d = ck_event | (iflag_q & ~(w_iflag & ck_b));
	wire [3:0] ckcnt_d = w_presc ? RSLP_CLOCK_READY_FLAG_CYC :
		(ckcnt_q != 4'h0 ? ckcnt_q - 4'h1 : 4'h0);
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ien_q   <= 1'b0;
			iflag_q <= 1'b0;
			ckcnt_q <= 4'h0;
			clock_ready_flag_q <= 1'b1;
		end else if (any_rst) begin
			ien_q   <= 1'b0;
			iflag_q <= 1'b0;
			ckcnt_q <= 4'h0;
			clock_ready_flag_q <= 1'b1;
		end else begin
			ien_q   <= ien_d;
			iflag_q <= iflag_d;
			ckcnt_q <= ckcnt_d;
			clock_ready_flag_q <= ~w_presc & (ckcnt_d == 4'h0);
		end
	end
	// Flag reads the live ready level so it is zero during the change
	wire flag_rd = iflag_q & clock_ready_flag_q;

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) irq_out <= 1'b0;
		else          irq_out <= iflag_d & ien_d & ~any_rst;
	end

	// ----------------------------------------------------------------
	// Sleep controller
	// ----------------------------------------------------------------
	rslp_state_t st_q, st_d;
	logic [1:0]  lvl_q;
	wire sleep_go = wait_for_interrupt_instr_in |
		(sleep_on_isr_exit_in & isr_exit_lowest_in);
	// Reserved level 3 is treated as the deepest idle level
	wire [1:0] lvl_sel = (idle_q == 2'h3) ? 2'h2 : idle_q;
	wire wake_idle = irq_async_in |
		(irq_sync_pbus_in & (lvl_q != 2'h2)) |
		(irq_sync_hs_in & (lvl_q == 2'h0));

	always_comb begin
		st_d = st_q;
		case (st_q)
			RSLP_ACTIVE: begin
				if (sleep_go)
					st_d = deep_sleep_select_in ?
						RSLP_STANDBY : RSLP_IDLE;
			end
			RSLP_IDLE: begin
				if (wake_idle) st_d = RSLP_ACTIVE;
			end
			RSLP_STANDBY: begin
				// Frozen except for the asynchronous wake path
				if (irq_async_in) st_d = RSLP_ACTIVE;
			end
			default: st_d = RSLP_ACTIVE;
		endcase
	end
	wire [1:0] lvl_d = (st_q == RSLP_ACTIVE && sleep_go) ? lvl_sel : lvl_q;

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q  <= RSLP_ACTIVE;
			lvl_q <= 2'h0;
		end else if (any_rst) begin
			st_q  <= RSLP_ACTIVE;
			lvl_q <= 2'h0;
		end else begin
			st_q  <= st_d;
			lvl_q <= lvl_d;
		end
	end

	// ----------------------------------------------------------------
	// Clock gating and oscillator control
	// ----------------------------------------------------------------
	wire nx_act  = (st_d == RSLP_ACTIVE);
	wire nx_stby = (st_d == RSLP_STANDBY);
	wire nx_idle = (st_d == RSLP_IDLE);
	wire cpu_en  = nx_act;
	wire hs_en   = nx_act | (nx_idle & lvl_d == 2'h0);
	wire pb_en   = nx_act | (nx_idle & lvl_d != 2'h2);
	// Low nibble: on-demand per osc; high nibble: run-in-standby per osc
	wire [3:0] od  = osccfg_q[3:0];
	wire [3:0] rs  = osccfg_q[7:4];
	wire [3:0] req = osc_request_in[3:0];
	wire [3:0] osc_idle = ~od | req;
	wire [3:0] osc_stby = rs & (~od | req);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cpu_clk_en_out    <= 1'b1;
			hs_clk_en_out     <= 1'b1;
			pbus_clk_en_out   <= 1'b1;
			main_clk_en_out   <= 1'b1;
			hs_mod_clk_en_out <= RSLP_HSMASK_RST;
			pa_mod_clk_en_out <= RSLP_PAMASK_RST;
			osc_run_out       <= 8'h0f;
			lowpower_out      <= 1'b0;
		end else begin
			cpu_clk_en_out    <= cpu_en;
			hs_clk_en_out     <= hs_en;
			pbus_clk_en_out   <= pb_en;
			main_clk_en_out   <= ~nx_stby;
			hs_mod_clk_en_out <= hsmask_q & {8{hs_en}};
			pa_mod_clk_en_out <= pamask_q & {8{pb_en}};
			osc_run_out       <= {4'h0, nx_stby ? osc_stby : osc_idle};
			lowpower_out      <= nx_stby;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr_in)
			RSLP_OFF_SLEEP:   rd_mux = {6'h00, idle_q};
			RSLP_OFF_CPUSEL:  rd_mux = {5'h00, cpudiv_q};
			RSLP_OFF_APBASEL: rd_mux = {5'h00, padiv_q};
			RSLP_OFF_APBBSEL: rd_mux = {5'h00, pbdiv_q};
			RSLP_OFF_APBCSEL: rd_mux = {5'h00, pcdiv_q};
			RSLP_OFF_HSMASK:  rd_mux = hsmask_q;
			RSLP_OFF_PAMASK:  rd_mux = pamask_q;
			RSLP_OFF_PBMASK:  rd_mux = pbmask_q;
			RSLP_OFF_PCMASK:  rd_mux = pcmask_q;
			RSLP_OFF_IENCLR:  rd_mux = {7'h00, ien_q};
			RSLP_OFF_IENSET:  rd_mux = {7'h00, ien_q};
			RSLP_OFF_IFLAG:   rd_mux = {7'h00, flag_rd};
			RSLP_OFF_RESET_CAUSE_REG:  rd_mux = reset_cause_reg_q;
			RSLP_OFF_OSCCFG:  rd_mux = osccfg_q;
			default:          rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)       reg_rdata_out <= 8'h00;
		else if (reg_rd_in) reg_rdata_out <= rd_mux;
		else                reg_rdata_out <= 8'h00;
	end
endmodule : rslp_ctrl
`default_nettype wire

// ### rtl/rslp_pkg.sv
package rslp_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RSLP_OFF_SLEEP   = 8'h01;
	localparam logic [7:0] RSLP_OFF_CPUSEL  = 8'h08;
	localparam logic [7:0] RSLP_OFF_APBASEL = 8'h09;
	localparam logic [7:0] RSLP_OFF_APBBSEL = 8'h0a;
	localparam logic [7:0] RSLP_OFF_APBCSEL = 8'h0b;
	localparam logic [7:0] RSLP_OFF_HSMASK  = 8'h14;
	localparam logic [7:0] RSLP_OFF_PAMASK  = 8'h18;
	localparam logic [7:0] RSLP_OFF_PBMASK  = 8'h1c;
	localparam logic [7:0] RSLP_OFF_PCMASK  = 8'h20;
	localparam logic [7:0] RSLP_OFF_IENCLR  = 8'h34;
	localparam logic [7:0] RSLP_OFF_IENSET  = 8'h35;
	localparam logic [7:0] RSLP_OFF_IFLAG   = 8'h36;
	localparam logic [7:0] RSLP_OFF_RESET_CAUSE_REG  = 8'h38;
	localparam logic [7:0] RSLP_OFF_OSCCFG  = 8'h3c;
	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int RSLP_CAUSE_POR  = 0;
	localparam int RSLP_CAUSE_CBOD = 1;
	localparam int RSLP_CAUSE_IBOD = 2;
	localparam int RSLP_CAUSE_EXT  = 4;
	localparam int RSLP_CAUSE_WDOG = 5;
	localparam int RSLP_CAUSE_SOFT = 6;
	localparam int RSLP_CLOCK_READY_FLAG_BIT  = 0;
	localparam logic [1:0] RSLP_IDLE_RST   = 2'h0;
	localparam logic [2:0] RSLP_DIV_RST    = 3'h0;
	localparam logic [7:0] RSLP_RESET_CAUSE_REG_RST = 8'h01;
	localparam logic [7:0] RSLP_HSMASK_RST = 8'h7f;
	localparam logic [7:0] RSLP_PAMASK_RST = 8'h7f;
	localparam logic [7:0] RSLP_PBMASK_RST = 8'h3f;
	localparam logic [7:0] RSLP_PCMASK_RST = 8'h00;
	localparam logic [7:0] RSLP_OSC_RST    = 8'h00;
	// Cycles from a prescaler write until the new setting is effective
	localparam logic [3:0] RSLP_CLOCK_READY_FLAG_CYC  = 4'h8;
	// ----------------------------------------------------------------
	// Sleep controller states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RSLP_ACTIVE  = 2'b00,
		RSLP_IDLE    = 2'b01,
		RSLP_STANDBY = 2'b11
	} rslp_state_t;
endpackage : rslp_pkg

// ### dv/rslp_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module rslp_ctrl_props (
	input wire logic       ref_clk_in,
	input wire logic       rstn_in,
	input wire logic       por_req_in,
	input wire logic       core_brownout_in,
	input wire logic       io_brownout_in,
	input wire logic       reset_pin_n_in,
	input wire logic       wdog_reset_in,
	input wire logic       cpu_soft_reset_request_in,
	input wire logic       wait_for_interrupt_instr_in,
	input wire logic       deep_sleep_select_in,
	input wire logic       irq_async_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       power_rst_n_out,
	input wire logic       debug_rst_n_out,
	input wire logic       sys_rst_n_out,
	input wire logic       cpu_clk_en_out,
	input wire logic       hs_clk_en_out,
	input wire logic       pbus_clk_en_out,
	input wire logic       main_clk_en_out,
	input wire logic [7:0] hs_mod_clk_en_out,
	input wire logic [7:0] pa_mod_clk_en_out,
	input wire logic       lowpower_out
);
	wire logic pwr = por_req_in | core_brownout_in | io_brownout_in;
	wire logic usr = wdog_reset_in | cpu_soft_reset_request_in;
	wire logic act = cpu_clk_en_out & main_clk_en_out;
	wire logic wait_for_interrupt_instr = wait_for_interrupt_instr_in;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	// Eight cycles cover the three-stage source synchroniser
	sequence s_pwr; pwr[*8]; endsequence
	sequence s_pin; (!reset_pin_n_in && !pwr)[*8]; endsequence
	sequence s_usr; (usr && reset_pin_n_in && !pwr)[*8]; endsequence
	AST_IDLE_ENTER: assert property (
		act && wait_for_interrupt_instr && !deep_sleep_select_in
		|=> !cpu_clk_en_out && main_clk_en_out && !lowpower_out)
		else $error("idle entry wrong");
	AST_STBY_ENTER: assert property (
		act && wait_for_interrupt_instr && deep_sleep_select_in |=> lowpower_out
		&& !main_clk_en_out && !cpu_clk_en_out && !hs_clk_en_out)
		else $error("standby entry wrong");
	AST_STBY_HOLD: assert property (
		lowpower_out && !irq_async_in |=> lowpower_out)
		else $error("standby left without async wake");
	AST_STBY_WAKE: assert property (
		lowpower_out && irq_async_in
		|=> !lowpower_out && main_clk_en_out && cpu_clk_en_out)
		else $error("standby wake missing");
	AST_HS_HALT: assert property (
		!hs_clk_en_out
		|-> hs_mod_clk_en_out == 8'h00)
		else $error("high-speed module clock runs");
	AST_PB_HALT: assert property (
		!pbus_clk_en_out
		|-> pa_mod_clk_en_out == 8'h00)
		else $error("peripheral module clock runs");
	AST_RDATA_ZERO: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
	AST_PWR_RST: assert property (
		s_pwr |-> !power_rst_n_out && !debug_rst_n_out && !sys_rst_n_out)
		else $error("power reset incomplete");
	AST_PIN_RST: assert property (
		s_pin |-> power_rst_n_out && !debug_rst_n_out && !sys_rst_n_out)
		else $error("pin reset reach wrong");
	AST_USR_RST: assert property (
		s_usr |-> power_rst_n_out && debug_rst_n_out && !sys_rst_n_out)
		else $error("user reset reach wrong");
endmodule : rslp_ctrl_props
bind rslp_ctrl rslp_ctrl_props u_props (
	.ref_clk_in                 (ref_clk_in),
	.rstn_in                    (rstn_in),
	.por_req_in                 (por_req_in),
	.core_brownout_in           (core_brownout_in),
	.io_brownout_in             (io_brownout_in),
	.reset_pin_n_in             (reset_pin_n_in),
	.wdog_reset_in              (wdog_reset_in),
	.cpu_soft_reset_request_in  (cpu_soft_reset_request_in),
	.wait_for_interrupt_instr_in(wait_for_interrupt_instr_in),
	.deep_sleep_select_in       (deep_sleep_select_in),
	.irq_async_in               (irq_async_in),
	.reg_rd_in                  (reg_rd_in),
	.reg_rdata_out              (reg_rdata_out),
	.power_rst_n_out            (power_rst_n_out),
	.debug_rst_n_out            (debug_rst_n_out),
	.sys_rst_n_out              (sys_rst_n_out),
	.cpu_clk_en_out             (cpu_clk_en_out),
	.hs_clk_en_out              (hs_clk_en_out),
	.pbus_clk_en_out            (pbus_clk_en_out),
	.main_clk_en_out            (main_clk_en_out),
	.hs_mod_clk_en_out          (hs_mod_clk_en_out),
	.pa_mod_clk_en_out          (pa_mod_clk_en_out),
	.lowpower_out               (lowpower_out)
);
`default_nettype wire

// ### dv/rslp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rslp_core_model (
	input  wire logic       ref_clk_in,
	output logic            wfi_out,
	output logic            exit_out,
	output logic      [2:0] irq_out,
	output logic            soe_out,
	output logic            deep_out,
	output logic      [7:0] req_out
);
	// Pulse bits: wfi, isr exit, sync hs, sync pbus, async
	logic [4:0] p_q = 5'h00;
	assign wfi_out  = p_q[0];
	assign exit_out = p_q[1];
	assign irq_out  = p_q[4:2];
	initial begin
		soe_out  = 1'h0;
		deep_out = 1'h0;
		req_out  = 8'h00;
	end
	// Returns just after the edge that sampled the pulse
	task automatic pulse(input int k);
		@(posedge ref_clk_in);
		p_q[k] <= 1'h1;
		@(posedge ref_clk_in);
		p_q[k] <= 1'h0;
		#1;
	endtask : pulse
	task automatic mode(input logic s, input logic d, input logic [7:0] r);
		@(posedge ref_clk_in);
		soe_out  <= s;
		deep_out <= d;
		req_out  <= r;
	endtask : mode
endmodule : rslp_core_model
`default_nettype wire

// ### dv/rslp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rslp_ctrl_tb;
	import rslp_pkg::*;
	logic       ref_clk_in = 1'h0;
	logic       rstn_in    = 1'h0;
	logic [5:0] src        = 6'h00;
	logic [7:0] addr       = 8'h00;
	logic [7:0] wdat       = 8'h00;
	logic       wr         = 1'h0;
	logic       rd         = 1'h0;
	logic       wait_for_interrupt_instr, iex, soe, deep, prn, drn, srn, cen, hen, pen, men, lp;
	logic       ck_irq;
	logic [2:0] irq;
	logic [7:0] oreq, rdat, hsm, pam, osc;
	int         miscompares = 0;
	int         checked     = 0;
	int         cb [6] = '{RSLP_CAUSE_POR, RSLP_CAUSE_CBOD, RSLP_CAUSE_IBOD,
		RSLP_CAUSE_EXT, RSLP_CAUSE_WDOG, RSLP_CAUSE_SOFT};
	logic [7:0] ra [7] = '{RSLP_OFF_SLEEP, RSLP_OFF_CPUSEL, RSLP_OFF_HSMASK,
		RSLP_OFF_PAMASK, RSLP_OFF_PBMASK, RSLP_OFF_PCMASK, 8'h02};
	logic [7:0] rv [7] = '{8'h00, 8'h00, RSLP_HSMASK_RST, RSLP_PAMASK_RST,
		RSLP_PBMASK_RST, RSLP_PCMASK_RST, 8'h00};
	always #50 ref_clk_in = ~ref_clk_in;
	rslp_ctrl DUT (
		.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.por_req_in(src[0]), .core_brownout_in(src[1]),
		.io_brownout_in(src[2]), .reset_pin_n_in(~src[3]),
		.wdog_reset_in(src[4]), .cpu_soft_reset_request_in(src[5]),
		.wait_for_interrupt_instr_in(wait_for_interrupt_instr), .isr_exit_lowest_in(iex),
		.sleep_on_isr_exit_in(soe), .deep_sleep_select_in(deep),
		.irq_sync_hs_in(irq[0]), .irq_sync_pbus_in(irq[1]),
		.irq_async_in(irq[2]), .osc_request_in(oreq),
		.reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdat), .power_rst_n_out(prn),
		.debug_rst_n_out(drn), .sys_rst_n_out(srn),
		.cpu_clk_en_out(cen), .hs_clk_en_out(hen),
		.pbus_clk_en_out(pen), .main_clk_en_out(men),
		.hs_mod_clk_en_out(hsm), .pa_mod_clk_en_out(pam),
		.osc_run_out(osc), .lowpower_out(lp), .irq_out(ck_irq)
	);
	rslp_core_model core (
		.ref_clk_in(ref_clk_in), .wfi_out(wait_for_interrupt_instr), .exit_out(iex),
		.irq_out(irq), .soe_out(soe), .deep_out(deep), .req_out(oreq)
	);
	// ----------------------------------------
	// Bus tasks and compares
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : cyc
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		wdat <= d;
		wr   <= 1'h1;
		@(posedge ref_clk_in);
		wr   <= 1'h0;
	endtask : wr8
	// Read data stand only in the cycle after the strobe
	task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk_in);
		addr <= a;
		rd   <= 1'h1;
		@(posedge ref_clk_in);
		rd   <= 1'h0;
		#1;
		chk(rdat, exp);
	endtask : rd8
	task automatic tally_and_finish;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk_in);
		rstn_in <= 1'h1;
		rd8(RSLP_OFF_RESET_CAUSE_REG, RSLP_RESET_CAUSE_REG_RST);
		for (int i = 0; i < 7; i++)
			rd8(ra[i], rv[i]);
		chk(hsm, RSLP_HSMASK_RST);
		$display("test reset values done");
		wr8(RSLP_OFF_IENSET, 8'h01);
		wr8(RSLP_OFF_CPUSEL, 8'h02);
		rd8(RSLP_OFF_IFLAG, 8'h00);
		cyc(12);
		rd8(RSLP_OFF_IFLAG, 8'h01);
		chk({7'h0, ck_irq}, 8'h01);
		wr8(RSLP_OFF_IFLAG, 8'h00);
		rd8(RSLP_OFF_IFLAG, 8'h01);
		wr8(RSLP_OFF_IENCLR, 8'h01);
		cyc(1);
		chk({7'h0, ck_irq}, 8'h00);
		wr8(RSLP_OFF_IENSET, 8'h01);
		cyc(1);
		chk({7'h0, ck_irq}, 8'h01);
		wr8(RSLP_OFF_IFLAG, 8'h01);
		cyc(1);
		chk({7'h0, ck_irq}, 8'h00);
		$display("test clock ready done");
		// Upper address bits must decode, not alias onto low offsets
		wr8(RSLP_OFF_PAMASK, 8'h55);
		wr8(RSLP_OFF_PCMASK, 8'h5a);
		wr8(8'hc1, 8'hff);
		cyc(1);
		chk(pam, 8'h55);
		rd8(RSLP_OFF_PCMASK, 8'h5a);
		rd8(RSLP_OFF_SLEEP, 8'h00);
		rd8(8'hc1, 8'h00);
		$display("test mask and decode done");
		// osc0 always, osc1 always plus standby, osc2 on demand, osc3 on demand plus standby
		wr8(RSLP_OFF_OSCCFG, 8'hac);
		for (int l = 0; l < 4; l++) begin
			wr8(RSLP_OFF_SLEEP, l[7:0]);
			core.mode(1'h0, 1'h0, 8'hf7);
			core.pulse(0);
			chk({4'h0, cen, hen, pen, men}, {5'h0, l == 0, l < 2, 1'h1});
			chk(osc, 8'h07);
			chk(pam, (l < 2) ? 8'h55 : 8'h00);
			core.pulse(2);
			chk({7'h0, cen}, {7'h0, l == 0});
			if (l > 0)
				core.pulse(3);
			chk({7'h0, cen}, {7'h0, l < 2});
			if (l > 1)
				core.pulse(4);
			chk({7'h0, cen}, 8'h01);
		end
		core.mode(1'h1, 1'h0, 8'h00);
		core.pulse(1);
		chk({7'h0, cen}, 8'h00);
		core.pulse(4);
		chk({7'h0, cen}, 8'h01);
		$display("test idle done");
		wr8(RSLP_OFF_HSMASK, 8'h00);
		core.mode(1'h0, 1'h1, 8'h0c);
		core.pulse(0);
		chk({4'h0, cen, men, lp, hen}, 8'h02);
		chk(osc, 8'h0a);
		core.pulse(2);
		core.pulse(3);
		chk({7'h0, lp}, 8'h01);
		core.pulse(4);
		chk({6'h0, lp, cen}, 8'h01);
		core.mode(1'h0, 1'h0, 8'h00);
		$display("test standby done");
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk_in);
			src <= 6'h01 << i;
			cyc(10);
			chk({5'h0, prn, drn, srn}, {5'h0, i > 2, i > 3, 1'h0});
			@(posedge ref_clk_in);
			src <= 6'h00;
			cyc(10);
			chk({5'h0, prn, drn, srn}, 8'h07);
			rd8(RSLP_OFF_RESET_CAUSE_REG, 8'h01 << cb[i]);
		end
		$display("test reset sources done");
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		miscompares++;
		tally_and_finish();
	end
endmodule : rslp_ctrl_tb
`default_nettype wire
